/* File: bench/sfp_egress_model.sv */
// Purpose: Egress transmitter on the far side of the output queues
// Assumes: One frame in flight, started only while its queue is allowed
// Notes:   Length lines show junk between frames, the last value and its inverse in turn
`timescale 1ns/100ps
module sfp_egress_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [11:0] tx_allow,
    input  wire logic        go,
    input  wire logic [3:0]  n,
    input  wire logic [1:0]  q_port,
    input  wire logic [1:0]  q_prio,
    output logic             tx_done,
    output logic      [1:0]  tx_port,
    output logic      [1:0]  tx_prio,
    output logic      [10:0] tx_len,
    output logic             busy
);
    logic [3:0] left_r;
    wire  [3:0] qi = {q_port - 2'd1, q_prio};
    assign tx_port = q_port;
    assign tx_prio = q_prio;
    assign busy    = left_r != 4'h0;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            left_r  <= 4'h0;
            tx_done <= 1'b0;
            tx_len  <= 11'h7ff;
        end
        else
        begin
            tx_done <= 1'b0;
            tx_len  <= ~tx_len;
            if (go)
                left_r <= n;
            // Skip the cycle after a send: allow only updates one cycle later
            else if (busy && !tx_done && tx_allow[qi])
            begin
                tx_done <= 1'b1;
                tx_len  <= 11'd64;
                left_r  <= left_r - 4'h1;
            end
        end
    end
endmodule : sfp_egress_model

/* File: bench/sfp_policy_monitor.sv */
// Purpose: Port-level checks of the forwarding decisions and shaping
// Assumes: Single hclk domain, hresetn asynchronous active low
// Notes:   Bound to the policy block from the bench top
`timescale 1ns/100ps
module sfp_policy_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic        fr_valid,
    input wire logic [1:0]  fr_src,
    input wire logic        fr_is_ip,
    input wire logic [3:0]  fr_ip_ver,
    input wire logic [7:0]  fr_ip_proto,
    input wire logic        fr_mcast,
    input wire logic        fr_bcast,
    input wire logic        fr_da_known,
    input wire logic [2:0]  mem_full,
    input wire logic        tx_done,
    input wire logic [11:0] tx_allow,
    input wire logic        dec_valid,
    input wire logic [2:0]  dec_mask,
    input wire logic        dec_drop,
    input wire logic        dec_learn,
    input wire logic [7:0]  dec_tail_out,
    input wire logic [2:0]  flow_ctrl
);
    default clocking mon_cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire igmp_w = fr_is_ip && fr_ip_ver == sfp_pkg::IGMP_IP_VER
                  && fr_ip_proto == sfp_pkg::IGMP_PROTO;
    sequence frame_s;
        fr_valid && fr_src != 2'd0;
    endsequence
    sequence igmp_net_s;
        fr_valid && igmp_w && (fr_src == 2'd1 || fr_src == 2'd2);
    endsequence
    igmp_trap_a: assert property (igmp_net_s |=> dec_valid && dec_mask[1:0] == 2'b00)
        else $error("igmp frame reached a network port");
    tail_source_a: assert property (igmp_net_s |=> dec_tail_out[0] == ($past(fr_src) == 2'd2))
        else $error("tail source bit wrong");
    src_excl_a: assert property (frame_s |=> (dec_mask & (3'b001 << ($past(fr_src) - 2'd1))) == 3'b000)
        else $error("frame sent back to its source");
    dec_origin_a: assert property (dec_valid |-> $past(fr_valid))
        else $error("decision without a frame");
    drop_mask_a: assert property (dec_valid && dec_drop |-> dec_mask == 3'b000)
        else $error("dropped frame still forwarded");
    uu_learn_a: assert property (fr_valid && !fr_mcast && !fr_bcast && !fr_da_known |=> !dec_learn)
        else $error("unknown unicast learned");
    flow_idle_a: assert property (mem_full == 3'b000 |=> flow_ctrl == 3'b000)
        else $error("flow control without full memory");
    egress_hold_a: assert property (|($past(tx_allow) & ~tx_allow) |-> $past(tx_done) || $past(hsel) || $past(hsel, 2))
        else $error("queue blocked without a send");
endmodule : sfp_policy_monitor

/* File: bench/sfp_policy_tb_top.sv */
// Purpose: Self-checking bench for the switch forwarding policy
// Assumes: Zero-wait AHB-Lite slave, accounting tick cut to 40 cycles
// Notes:   Descriptors are sent one at a time with a gap cycle
`timescale 1ns/100ps
module sfp_policy_tb_top;
    localparam int TICK = 40;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0]  htrans = 2'h0, fr_src = 2'h0, fr_prio = 2'h0, tx_port, tx_prio, dec_prio;
    logic [2:0]  hsize = 3'h2, link_10m = 3'h0, fr_lookup_mask = 3'h0, mem_full = 3'h0;
    logic        fr_valid = 1'b0, fr_is_ip = 1'b1, fr_mcast = 1'b0, fr_bcast = 1'b0;
    logic        fr_da_known = 1'b1, fr_rx_err = 1'b0, tx_done, busy, hreadyout, hresp;
    logic [3:0]  fr_ip_ver = 4'h4;
    logic [7:0]  fr_ip_proto = 8'h02, fr_tail = 8'h00, dec_tail_out;
    logic [10:0] fr_len = 11'd64, tx_len;
    logic [11:0] tx_allow;
    logic        dec_valid, dec_drop, dec_learn, dec_strip_tail, dec_append_tail;
    logic [2:0]  dec_mask, flow_ctrl;
    wire logic   hready = hreadyout;
    int          err_count = 0, checks = 0, cyc = 0, wt;
    sfp_policy #(.TICK_CYCLES(TICK)) dut_u (.*);
    sfp_egress_model eg_u (.hclk, .hresetn, .tx_allow, .go, .n(4'h2), .q_port(2'd2),
                           .q_prio(2'd0), .tx_done, .tx_port, .tx_prio, .tx_len, .busy);
    initial forever #12.5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'b00};
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rdv = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        ahb(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0);
        chk(nm, rdv, exp);
        chk("okay response", {31'h0, hresp}, 32'h0);
    endtask : rdc
    task automatic fr(input logic [1:0] s, input logic [2:0] m, input logic [7:0] t);
        @(posedge hclk);
        fr_valid       <= 1'b1;
        fr_src         <= s;
        fr_lookup_mask <= m;
        fr_tail        <= t;
        @(posedge hclk);
        fr_valid <= 1'b0;
        #1;
    endtask : fr
    task automatic mir(input logic [7:0] p1, p2, g5, input logic [1:0] s, input logic [2:0] m, x);
        wr(sfp_pkg::REG_PORT1, {24'h0, p1});
        wr(sfp_pkg::REG_PORT2, {24'h0, p2});
        wr(sfp_pkg::REG_GCTL5, {24'h0, g5});
        fr(s, m, 8'h00);
        chk("mirror mask", {29'h0, dec_mask}, {29'h0, x});
    endtask : mir
    task automatic pair(input logic d0, input logic d1);
        fr(2'd1, 3'b010, 8'h00);
        chk("first drop", {31'h0, dec_drop}, {31'h0, d0});
        fr(2'd1, 3'b010, 8'h00);
        chk("second drop", {31'h0, dec_drop}, {31'h0, d1});
    endtask : pair
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("gctl3 reset", sfp_pkg::REG_GCTL3, 32'h0);
        wr(sfp_pkg::REG_PORT3, 32'h80);
        rdc("port3", sfp_pkg::REG_PORT3, 32'h80);
        wr(8'h7f, 32'hff);
        rdc("unmapped", 8'h7f, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            fr_is_ip    <= (i != 3);
            fr_ip_ver   <= (i == 1) ? 4'h6 : 4'h4;
            fr_ip_proto <= (i == 2) ? 8'h06 : 8'h02;
            fr(2'd1, 3'b010, 8'h00);
            chk("igmp mask", {29'h0, dec_mask}, (i == 0) ? 32'h4 : 32'h2);
        end
        fr_is_ip <= 1'b1;
        fr_ip_proto <= 8'h02;
        wr(sfp_pkg::REG_GCTL3, 32'h40);
        fr(2'd2, 3'b001, 8'h00);
        chk("tail append", {31'h0, dec_append_tail}, 32'h1);
        chk("tail source", {31'h0, dec_tail_out[0]}, 32'h1);
        fr_ip_proto <= 8'h06;
        for (int i = 0; i < 4; i++)
        begin
            fr(2'd3, 3'b010, {4'h0, i[1:0], i[1:0]});
            chk("host mask", {29'h0, dec_mask}, (i == 0) ? 32'h2 : i);
            chk("host prio", {30'h0, dec_prio}, i);
            chk("tail strip", {31'h0, dec_strip_tail}, 32'h1);
        end
        wr(sfp_pkg::REG_GCTL3, 32'h0);
        fr(2'd3, 3'b010, 8'h01);
        chk("tail off", {29'h0, dec_mask}, 32'h2);
        $display("test igmp and tail done");
        mir(8'h40, 8'h00, 8'h00, 2'd1, 3'b010, 3'b110);
        mir(8'h40, 8'h00, 8'h00, 2'd1, 3'b100, 3'b100);
        mir(8'h00, 8'h20, 8'h00, 2'd1, 3'b010, 3'b110);
        mir(8'h40, 8'h20, 8'h01, 2'd1, 3'b010, 3'b110);
        mir(8'h40, 8'h00, 8'h01, 2'd1, 3'b010, 3'b010);
        mir(8'h40, 8'h40, 8'h00, 2'd2, 3'b001, 3'b101);
        fr_rx_err <= 1'b1;
        mir(8'h40, 8'h00, 8'h02, 2'd1, 3'b010, 3'b100);
        fr_rx_err <= 1'b0;
        mir(8'h00, 8'h00, 8'h00, 2'd1, 3'b010, 3'b010);
        $display("test mirror done");
        fr_da_known <= 1'b0;
        fr(2'd1, 3'b000, 8'h00);
        chk("uu drop", {31'h0, dec_drop}, 32'h1);
        wr(sfp_pkg::REG_UUCAST, 32'h84);
        fr(2'd1, 3'b000, 8'h00);
        chk("uu fwd", {29'h0, dec_mask}, 32'h4);
        chk("uu learn", {31'h0, dec_learn}, 32'h0);
        fr_da_known <= 1'b1;
        fr_prio <= 2'd1;
        wr(8'h41, 32'h1);
        wr(sfp_pkg::REG_RCFG, 32'h4);
        pair(1'b0, 1'b0);
        wr(sfp_pkg::REG_RCFG, 32'h0);
        pair(1'b0, 1'b1);
        fr_len <= 11'd1518;
        wr(8'h41, 32'h1a);
        pair(1'b0, 1'b1);
        link_10m <= 3'b001;
        // Let the speed pin pass its two sync stages and the bucket clear
        repeat (4) @(posedge hclk);
        pair(1'b0, 1'b0);
        $display("test unicast and ingress done");
        wr(8'h54, 32'h1);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        wt = 0;
        while (tx_allow[4] !== 1'b0 && wt < 100)
        begin
            @(posedge hclk);
            #1;
            wt++;
        end
        chk("egress block", {31'h0, tx_allow[4]}, 32'h0);
        chk("other queue", {31'h0, tx_allow[5]}, 32'h1);
        wt = 0;
        while (busy && wt < 2000)
        begin
            @(posedge hclk);
            wt++;
        end
        chk("egress gap", {31'h0, wt > 4 * TICK}, 32'h1);
        mem_full <= 3'b010;
        fr(2'd1, 3'b010, 8'h00);
        chk("full drop", {31'h0, dec_drop}, 32'h1);
        wr(sfp_pkg::REG_GCTL5, 32'h4);
        fr(2'd1, 3'b010, 8'h00);
        chk("pause", {29'h0, flow_ctrl}, 32'h7);
        chk("paused pass", {31'h0, dec_drop}, 32'h0);
        $display("test egress and memory done");
        complete_run();
    end
endmodule : sfp_policy_tb_top
bind sfp_policy sfp_policy_monitor mon_u (.hclk, .hresetn, .hsel, .fr_valid, .fr_src,
    .fr_is_ip, .fr_ip_ver, .fr_ip_proto, .fr_mcast, .fr_bcast, .fr_da_known, .mem_full,
    .tx_done, .tx_allow, .dec_valid, .dec_mask, .dec_drop, .dec_learn, .dec_tail_out,
    .flow_ctrl);

/* File: hw/sfp_pkg.sv */
// Purpose: Constants shared by the switch forwarding policy block
// Assumes: 40 MHz hclk, 32-bit AHB-Lite register bus
// Notes:   Register byte address is four times the register index
package sfp_pkg;
    // Register indices
    localparam logic [7:0] REG_GCTL3   = 8'h03;
    localparam logic [7:0] REG_GCTL5   = 8'h05;
    localparam logic [7:0] REG_UUCAST  = 8'h0e;
    localparam logic [7:0] REG_PORT1   = 8'h11;
    localparam logic [7:0] REG_PORT2   = 8'h21;
    localparam logic [7:0] REG_PORT3   = 8'h31;
    localparam logic [7:0] REG_ING_B   = 8'h40;
    localparam logic [7:0] REG_EGR_B   = 8'h50;
    localparam logic [7:0] REG_RCFG    = 8'h60;
    localparam logic [7:0] REG_STAT    = 8'h61;
    // Field positions
    localparam int TAIL_EN_BIT  = 6;
    localparam int MIR_AND_BIT  = 0;
    localparam int MIR_BAD_BIT  = 1;
    localparam int FC_EN_BIT    = 2;
    localparam int UU_FWD_BIT   = 7;
    localparam int SNIFFER_BIT  = 7;
    localparam int RX_SNIFF_BIT = 6;
    localparam int TX_SNIFF_BIT = 5;
    // Reset values
    localparam logic [7:0] GCTL3_RST = 8'h00;
    localparam logic [7:0] GCTL5_RST = 8'h00;
    localparam logic [7:0] UU_RST    = 8'h00;
    localparam logic [7:0] PORT_RST  = 8'h00;
    localparam logic [6:0] RATE_RST  = 7'h00;
    localparam logic [3:0] RCFG_RST  = 4'h0;
    // Frame classification
    localparam logic [3:0] IGMP_IP_VER = 4'h4;
    localparam logic [7:0] IGMP_PROTO  = 8'h02;
    localparam logic [1:0] LEN_IFG     = 2'h1;
    localparam logic [1:0] LEN_PRE     = 2'h2;
    localparam logic [4:0] IFG_BYTES   = 5'h0c;
    localparam logic [4:0] PRE_BYTES   = 5'h08;
    localparam logic [1:0] CAT_ALL     = 2'h0;
    localparam logic [1:0] CAT_MCAST   = 2'h1;
    localparam logic [1:0] CAT_BCAST   = 2'h2;
    localparam logic [1:0] CAT_FLOOD   = 2'h3;
    // Rate codes: 1..15 are 64 kbps steps, 16 and up are 1 Mbps steps
    localparam logic [6:0] CODE_KBPS_MAX = 7'h0f;
    localparam logic [6:0] CODE_10M      = 7'h19;
    localparam logic [6:0] KSTEP_BYTES   = 7'h08;
    localparam logic [6:0] MSTEP_BYTES   = 7'h7d;
    // Accounting interval
    localparam int CLK_MHZ     = 40;
    localparam int TICK_US     = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int NPORT       = 3;
    localparam int NPRIO       = 4;
    localparam int NQ          = NPORT * NPRIO;
endpackage : sfp_pkg

/* File: hw/sfp_policy.sv */
// Purpose: Forwarding policy of a three-port switch: IGMP trap, tail tag,
//          mirroring, ingress/egress rate limits, unknown unicast filter
// Assumes: Frame fields are parsed upstream on hclk; one descriptor a cycle
// Notes:   Decision appears one cycle after fr_valid
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module sfp_policy #(
    parameter int TICK_CYCLES = sfp_pkg::TICK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [2:0]  link_10m,
    input  wire logic        fr_valid,
    input  wire logic [1:0]  fr_src,
    input  wire logic        fr_is_ip,
    input  wire logic [3:0]  fr_ip_ver,
    input  wire logic [7:0]  fr_ip_proto,
    input  wire logic        fr_mcast,
    input  wire logic        fr_bcast,
    input  wire logic        fr_da_known,
    input  wire logic [2:0]  fr_lookup_mask,
    input  wire logic        fr_rx_err,
    input  wire logic [10:0] fr_len,
    input  wire logic [1:0]  fr_prio,
    input  wire logic [7:0]  fr_tail,
    input  wire logic [2:0]  mem_full,
    input  wire logic        tx_done,
    input  wire logic [1:0]  tx_port,
    input  wire logic [1:0]  tx_prio,
    input  wire logic [10:0] tx_len,
    output logic      [11:0] tx_allow,
    output logic             dec_valid,
    output logic      [2:0]  dec_mask,
    output logic      [1:0]  dec_prio,
    output logic             dec_drop,
    output logic             dec_learn,
    output logic             dec_strip_tail,
    output logic             dec_append_tail,
    output logic      [7:0]  dec_tail_out,
    output logic      [2:0]  flow_ctrl
);
    localparam int NQ = sfp_pkg::NQ;
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    // Bytes per tick for a rate code; zero stands for unlimited
    function automatic logic [19:0] rate_inc(input logic [6:0] code, input logic is10);
        logic [19:0] r;
        r = '0;
        if (code == '0 || (is10 && code > sfp_pkg::CODE_10M))
            r = '0;
        else if (code <= sfp_pkg::CODE_KBPS_MAX)
            r = 20'(code) * 20'(sfp_pkg::KSTEP_BYTES);
        else
            r = 20'(code - sfp_pkg::CODE_KBPS_MAX) * 20'(sfp_pkg::MSTEP_BYTES);
        return r;
    endfunction : rate_inc

    logic [7:0]  gctl3_r;
    logic [7:0]  gctl5_r;
    logic [7:0]  uu_r;
    logic [7:0]  port_r [3];
    logic [6:0]  ing_rate_r [NQ];
    logic [6:0]  egr_rate_r [NQ];
    logic [3:0]  rcfg_r;
    logic        wr_pend_r;
    logic [7:0]  wr_idx_r;
    logic [31:0] hrdata_r;
    logic [2:0]  l10_s1_r;
    logic [2:0]  l10_r;
    logic [16:0] tick_cnt_r;
    logic        tick;
    logic [19:0] ing_lvl_r [NQ];
    logic [19:0] egr_lvl_r [NQ];
    logic [19:0] ing_inc [NQ];
    logic [19:0] egr_inc [NQ];
    logic [NQ-1:0] ing_over;

    // Bus decode; the slave never inserts wait states
    wire        addr_ok  = hsel && hready && htrans[1];
    wire [7:0]  a_idx    = haddr[9:2];
    wire        a_ing    = a_idx[7:4] == sfp_pkg::REG_ING_B[7:4] && a_idx[3:0] < 4'(NQ);
    wire        a_egr    = a_idx[7:4] == sfp_pkg::REG_EGR_B[7:4] && a_idx[3:0] < 4'(NQ);
    wire        w_ing    = wr_idx_r[7:4] == sfp_pkg::REG_ING_B[7:4] && wr_idx_r[3:0] < 4'(NQ);
    wire        w_egr    = wr_idx_r[7:4] == sfp_pkg::REG_EGR_B[7:4] && wr_idx_r[3:0] < 4'(NQ);
    wire [31:0] rd_val   =
        a_idx == sfp_pkg::REG_GCTL3 ? {24'h0, gctl3_r} :
        a_idx == sfp_pkg::REG_GCTL5 ? {24'h0, gctl5_r} :
        a_idx == sfp_pkg::REG_UUCAST ? {24'h0, uu_r} :
        a_idx == sfp_pkg::REG_PORT1 ? {24'h0, port_r[0]} :
        a_idx == sfp_pkg::REG_PORT2 ? {24'h0, port_r[1]} :
        a_idx == sfp_pkg::REG_PORT3 ? {24'h0, port_r[2]} :
        a_ing ? {25'h0, ing_rate_r[a_idx[3:0]]} :
        a_egr ? {25'h0, egr_rate_r[a_idx[3:0]]} :
        a_idx == sfp_pkg::REG_RCFG ? {28'h0, rcfg_r} :
        a_idx == sfp_pkg::REG_STAT ? {8'h0, ing_over, 3'h0, flow_ctrl, l10_r, mem_full} :
        32'h0;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
            hrdata_r  <= 32'h0;
        end
        else
        begin
            wr_pend_r <= addr_ok && hwrite;
            wr_idx_r  <= a_idx;
            if (addr_ok && !hwrite)
                hrdata_r <= rd_val;
        end
    end

    // Per-port sniff settings sit in their own registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gctl3_r <= sfp_pkg::GCTL3_RST;
            gctl5_r <= sfp_pkg::GCTL5_RST;
            uu_r    <= sfp_pkg::UU_RST;
            port_r  <= '{default: sfp_pkg::PORT_RST};
            rcfg_r  <= sfp_pkg::RCFG_RST;
        end
        else if (wr_pend_r)
        begin
            if (wr_idx_r == sfp_pkg::REG_GCTL3) gctl3_r <= hwdata[7:0];
            if (wr_idx_r == sfp_pkg::REG_GCTL5) gctl5_r <= hwdata[7:0];
            if (wr_idx_r == sfp_pkg::REG_UUCAST) uu_r <= hwdata[7:0];
            if (wr_idx_r == sfp_pkg::REG_PORT1) port_r[0] <= hwdata[7:0];
            if (wr_idx_r == sfp_pkg::REG_PORT2) port_r[1] <= hwdata[7:0];
            if (wr_idx_r == sfp_pkg::REG_PORT3) port_r[2] <= hwdata[7:0];
            if (wr_idx_r == sfp_pkg::REG_RCFG) rcfg_r <= hwdata[3:0];
        end
    end

    // Link speed pins come from the PHYs, outside this clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            l10_s1_r <= 3'h0;
            l10_r    <= 3'h0;
        end
        else
        begin
            l10_s1_r <= link_10m;
            l10_r    <= l10_s1_r;
        end
    end

    assign tick = tick_cnt_r == TICK_LAST;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tick_cnt_r <= 17'h0;
        else
            tick_cnt_r <= tick ? 17'h0 : tick_cnt_r + 17'h1;
    end

    // Frame classification and destination choice
    wire [1:0]  src_idx  = fr_src - 2'h1;
    wire [2:0]  src_bit  = 3'h1 << src_idx;
    wire        is_host  = fr_src == 2'h3;
    wire        tail_on  = gctl3_r[sfp_pkg::TAIL_EN_BIT];
    wire        is_igmp  = fr_is_ip && fr_ip_ver == sfp_pkg::IGMP_IP_VER
                           && fr_ip_proto == sfp_pkg::IGMP_PROTO && !is_host;
    wire        uu       = !fr_mcast && !fr_bcast && !fr_da_known;
    wire        host_sel = is_host && tail_on && fr_tail[1:0] != 2'h0;
    wire [2:0]  uu_mask  = uu_r[sfp_pkg::UU_FWD_BIT] ? uu_r[2:0] : 3'h0;
    wire [2:0]  base     = host_sel ? {1'b0, fr_tail[1:0]} :
                           uu ? uu_mask : fr_lookup_mask;
    wire [1:0]  prio     = (is_host && tail_on) ? fr_tail[3:2] : fr_prio;
    wire [2:0]  rxs_v    = {port_r[2][sfp_pkg::RX_SNIFF_BIT], port_r[1][sfp_pkg::RX_SNIFF_BIT],
                            port_r[0][sfp_pkg::RX_SNIFF_BIT]};
    wire [2:0]  txs_v    = {port_r[2][sfp_pkg::TX_SNIFF_BIT], port_r[1][sfp_pkg::TX_SNIFF_BIT],
                            port_r[0][sfp_pkg::TX_SNIFF_BIT]};
    wire [2:0]  sniff_v  = {port_r[2][sfp_pkg::SNIFFER_BIT], port_r[1][sfp_pkg::SNIFFER_BIT],
                            port_r[0][sfp_pkg::SNIFFER_BIT]};
    wire        rx_hit   = |(rxs_v & src_bit);
    wire        tx_hit   = |(base & txs_v);
    wire        mirror   = gctl5_r[sfp_pkg::MIR_AND_BIT] ? (rx_hit && tx_hit)
                                                          : (rx_hit || tx_hit);
    // OR-merging the sniffer port keeps a port that is both target and sniffer to one copy
    wire [2:0]  good     = is_igmp ? 3'b100 : (base | (mirror ? sniff_v : 3'h0));
    wire [2:0]  bad      = (gctl5_r[sfp_pkg::MIR_BAD_BIT] && rx_hit) ? sniff_v : 3'h0;
    wire [2:0]  fmask    = (fr_rx_err ? bad : good) & ~src_bit;
    wire        fc_en    = gctl5_r[sfp_pkg::FC_EN_BIT];

    // Ingress accounting
    wire [4:0]  extra    = rcfg_r[1:0] == sfp_pkg::LEN_IFG ? sfp_pkg::IFG_BYTES :
                           rcfg_r[1:0] == sfp_pkg::LEN_PRE ? sfp_pkg::PRE_BYTES : 5'h0;
    wire [19:0] clen     = 20'(fr_len) + 20'(extra);
    wire [1:0]  cat      = rcfg_r[3:2];
    wire        counted  = cat == sfp_pkg::CAT_ALL ||
                           (cat == sfp_pkg::CAT_MCAST && fr_mcast) ||
                           (cat == sfp_pkg::CAT_BCAST && fr_bcast) ||
                           (cat == sfp_pkg::CAT_FLOOD && uu && uu_mask != 3'h0);
    wire [3:0]  ing_q    = {src_idx, prio};
    wire        ing_drop = counted && ing_over[ing_q];
    wire        mem_drop = |(fmask & mem_full) && !fc_en;
    wire        drop     = fmask == 3'h0 || ing_drop || mem_drop;
    wire        ing_add  = fr_valid && fr_src != 2'h0 && counted && !ing_drop;
    wire [3:0]  egr_q    = {tx_port - 2'h1, tx_prio};
    wire        egr_add  = tx_done && tx_port != 2'h0;

    // Buckets drain once a tick by the programmed bytes per tick
    for (genvar q = 0; q < NQ; q++)
    begin : g_bucket
        wire [19:0] ing_dr = (tick && ing_lvl_r[q] > ing_inc[q]) ? ing_lvl_r[q] - ing_inc[q] :
                             tick ? 20'h0 : ing_lvl_r[q];
        wire [19:0] egr_dr = (tick && egr_lvl_r[q] > egr_inc[q]) ? egr_lvl_r[q] - egr_inc[q] :
                             tick ? 20'h0 : egr_lvl_r[q];
        wire [19:0] ing_nxt = ing_dr + ((ing_add && ing_q == 4'(q)) ? clen : 20'h0);
        wire [19:0] egr_len = 20'(tx_len) + 20'(extra);
        wire [19:0] egr_nxt = egr_dr + ((egr_add && egr_q == 4'(q)) ? egr_len : 20'h0);

        assign ing_inc[q]  = rate_inc(ing_rate_r[q], l10_r[q / sfp_pkg::NPRIO]);
        assign egr_inc[q]  = rate_inc(egr_rate_r[q], l10_r[q / sfp_pkg::NPRIO]);
        assign ing_over[q] = ing_inc[q] != 20'h0 && ing_lvl_r[q] > ing_inc[q];
        // Holding the queue off until the bucket drains stretches the gap per frame
        assign tx_allow[q] = egr_inc[q] == 20'h0 || egr_lvl_r[q] < egr_inc[q];

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                ing_lvl_r[q]  <= 20'h0;
                egr_lvl_r[q]  <= 20'h0;
                ing_rate_r[q] <= sfp_pkg::RATE_RST;
                egr_rate_r[q] <= sfp_pkg::RATE_RST;
            end
            else
            begin
                ing_lvl_r[q] <= ing_inc[q] == 20'h0 ? 20'h0 : ing_nxt;
                egr_lvl_r[q] <= egr_inc[q] == 20'h0 ? 20'h0 : egr_nxt;
                if (wr_pend_r && w_ing && wr_idx_r[3:0] == 4'(q))
                    ing_rate_r[q] <= hwdata[6:0];
                if (wr_pend_r && w_egr && wr_idx_r[3:0] == 4'(q))
                    egr_rate_r[q] <= hwdata[6:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dec_valid       <= 1'b0;
            dec_mask        <= 3'h0;
            dec_prio        <= 2'h0;
            dec_drop        <= 1'b0;
            dec_learn       <= 1'b0;
            dec_strip_tail  <= 1'b0;
            dec_append_tail <= 1'b0;
            dec_tail_out    <= 8'h00;
            flow_ctrl       <= 3'h0;
        end
        else
        begin
            dec_valid       <= fr_valid;
            dec_mask        <= drop ? 3'h0 : fmask;
            dec_prio        <= prio;
            dec_drop        <= drop;
            dec_learn       <= !uu && !fr_rx_err;
            dec_strip_tail  <= is_host && tail_on;
            dec_append_tail <= tail_on && !is_host && fmask[2] && !drop;
            dec_tail_out    <= {7'h00, src_idx == 2'h1};
            flow_ctrl       <= (fc_en && mem_full != 3'h0) ? 3'h7 : 3'h0;
        end
    end
endmodule : sfp_policy
